// ---- logic/power_mode_control.v ----
// power mode control: supply, regulator, halver and lcd supply bits
//
// Summary of operation
// - reset puts both halvers in normal mode
// - reset clears lcd, regulator, voltage, clock, oscillator
// - two halver bits selected independently
// - lcd supply circuit follows lcd_supply_on
// - contrast code has sixteen settings
// - external lcd supply keeps circuit off
// - voltage halver always runs
// - bits mapped at ff00 and ff60
`timescale 1ns/1ps

`include "power_mode_control_defines.vh"

module power_mode_control (
  input wire clock_i,
  input wire rst_i,
  input wire clk_en_i,
  input wire [15:0] addr_i,
  input wire wr_i,
  input wire [3:0] wdata_i,
  input wire [3:0] contrast_code_i,
  input wire contrast_wr_i,
  input wire cpu_clock_select_i,
  input wire clock_select_wr_i,
  input wire fast_osc_on_i,
  input wire fast_osc_wr_i,
  input wire ext_lcd_supply_i,
  output wire [3:0] rdata_o,
  output wire logic_voltage_select_o,
  output wire fast_regulator_on_o,
  output wire slow_regulator_halver_o,
  output wire lcd_supply_halver_o,
  output wire lcd_supply_on_o,
  output wire lcd_circuit_active_o,
  output wire cpu_clock_select_o,
  output wire fast_osc_on_o,
  output wire [3:0] contrast_code_o,
  output wire halver_running_o
);

  //////////////////////////////////////////////////////////////////////////////
  // address decode

  function sel_addr;
    input [15:0] a;
    input [15:0] want;
    begin
      sel_addr = (a == want);
    end
  endfunction

  wire hit_supply;
  wire hit_lcd;
  assign hit_supply = sel_addr(addr_i, `PMC_ADDR_SUPPLY);
  assign hit_lcd = sel_addr(addr_i, `PMC_ADDR_LCD);

  //////////////////////////////////////////////////////////////////////////////
  // control registers
  //
  // each register holds unless its own strobe is taken on an enabled edge,
  // so a low enable freezes the whole block; reset wins over the enable

  // every strobe needs the enable; only the ff00 and ff60 writes also need an address hit, the rest tie it high
  function take_write;
    input en;
    input strobe;
    input hit;
    begin
      take_write = en & strobe & hit;
    end
  endfunction

  wire supply_we;
  wire lcd_we;
  wire contrast_we;
  wire clk_sel_we;
  wire osc_on_we;

  assign supply_we = take_write(clk_en_i, wr_i, hit_supply);
  assign lcd_we = take_write(clk_en_i, wr_i, hit_lcd);
  assign contrast_we = take_write(clk_en_i, contrast_wr_i, 1'h1);
  // clock select and oscillator enable have no address of their own here
  assign clk_sel_we = take_write(clk_en_i, clock_select_wr_i, 1'h1);
  assign osc_on_we = take_write(clk_en_i, fast_osc_wr_i, 1'h1);

  reg [3:0] supply_q;
  wire [3:0] supply_d;
  reg lcd_on_q;
  reg lcd_on_d;
  reg clk_sel_q;
  reg clk_sel_d;
  reg osc_on_q;
  reg osc_on_d;
  reg [3:0] contrast_q;
  reg [3:0] contrast_d;

  //////////////////////////////////////////////////////////////////////////////
  // supply nibble next value

  // bit by bit, so either halver bit may be changed without the other
  genvar b;
  generate
    for (b = 0; b < 4; b = b + 1) begin : g_supply_bit
      assign supply_d[b] = supply_we ? wdata_i[b] : supply_q[b];
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // next values of the single bits and the contrast code

  always @* begin
    lcd_on_d = lcd_on_q;
    clk_sel_d = clk_sel_q;
    osc_on_d = osc_on_q;
    contrast_d = contrast_q;
    if (lcd_we) begin
      // only bit 0 is stored; the upper bits of this nibble read zero
      lcd_on_d = wdata_i[`PMC_BIT_LCD_ON];
    end
    if (contrast_we) begin
      contrast_d = contrast_code_i;
    end
    if (clk_sel_we) begin
      clk_sel_d = cpu_clock_select_i;
    end
    if (osc_on_we) begin
      osc_on_d = fast_osc_on_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state: one process per register, reset acts whatever the enable holds

  always @(posedge clock_i) begin
    if (rst_i) begin
      supply_q <= `PMC_SUPPLY_RST;
    end else begin
      supply_q <= supply_d;
    end
  end

  always @(posedge clock_i) begin
    if (rst_i) begin
      lcd_on_q <= `PMC_LCD_ON_RST;
    end else begin
      lcd_on_q <= lcd_on_d;
    end
  end

  always @(posedge clock_i) begin
    if (rst_i) begin
      clk_sel_q <= `PMC_CLK_SEL_RST;
    end else begin
      clk_sel_q <= clk_sel_d;
    end
  end

  always @(posedge clock_i) begin
    if (rst_i) begin
      osc_on_q <= `PMC_OSC_ON_RST;
    end else begin
      osc_on_q <= osc_on_d;
    end
  end

  always @(posedge clock_i) begin
    if (rst_i) begin
      contrast_q <= `PMC_CONTRAST_RST;
    end else begin
      contrast_q <= contrast_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read back: reads only select, nothing is cleared on read

  reg [3:0] read_mux;

  always @* begin
    read_mux = 4'h0;
    case ({hit_lcd, hit_supply})
      2'h1: begin
        read_mux = supply_q;
      end
      2'h2: begin
        read_mux = {3'h0, lcd_on_q};
      end
      default: begin
        // unmapped addresses read zero and touch no state
        read_mux = 4'h0;
      end
    endcase
  end

  assign rdata_o = read_mux;

  //////////////////////////////////////////////////////////////////////////////
  // lcd supply circuit

  // the mask option is a fixed strap, so it needs no synchroniser; with an
  // external supply the internal circuit stays off whatever software writes
  wire lcd_internal_ok;
  assign lcd_internal_ok = ~ext_lcd_supply_i;
  assign lcd_circuit_active_o = lcd_on_q & lcd_internal_ok;

  //////////////////////////////////////////////////////////////////////////////
  // outputs; ordering of mode moves is software's duty, not checked here

  assign logic_voltage_select_o = supply_q[`PMC_BIT_LOGIC_VSEL];
  assign fast_regulator_on_o = supply_q[`PMC_BIT_FAST_REG];
  assign slow_regulator_halver_o = supply_q[`PMC_BIT_SLOW_HALVER];
  assign lcd_supply_halver_o = supply_q[`PMC_BIT_LCD_HALVER];
  assign lcd_supply_on_o = lcd_on_q;
  assign cpu_clock_select_o = clk_sel_q;
  assign fast_osc_on_o = osc_on_q;
  assign contrast_code_o = contrast_q;
  // the halver has no off state; mode bits only pick its consumers
  assign halver_running_o = 1'h1;

endmodule // power_mode_control

// ---- logic/power_mode_control_defines.vh ----
// constants for the power mode control block
`ifndef POWER_MODE_CONTROL_DEFINES_VH
`define POWER_MODE_CONTROL_DEFINES_VH

// supply control nibble at 16'hff00
`define PMC_ADDR_SUPPLY 16'hff00
// lcd control nibble at 16'hff60
`define PMC_ADDR_LCD 16'hff60

// field positions in the supply nibble
`define PMC_BIT_LOGIC_VSEL 0
`define PMC_BIT_FAST_REG 1
`define PMC_BIT_SLOW_HALVER 2
`define PMC_BIT_LCD_HALVER 3
// field position in the lcd nibble
`define PMC_BIT_LCD_ON 0

// reset values
`define PMC_SUPPLY_RST 4'h0
`define PMC_LCD_ON_RST 1'h0
`define PMC_CLK_SEL_RST 1'h0
`define PMC_OSC_ON_RST 1'h0
`define PMC_CONTRAST_RST 4'h0

`endif

// ---- tb/power_mode_control_assertions.sv ----
// assertion checker for the power mode control block
`timescale 1ns/1ps
module pmc_chk (
  input wire clock_i,
  input wire rst_i,
  input wire clk_en_i,
  input wire [15:0] addr_i,
  input wire wr_i,
  input wire [3:0] wdata_i,
  input wire [3:0] contrast_code_i,
  input wire contrast_wr_i,
  input wire ext_lcd_supply_i,
  input wire [3:0] rdata_o,
  input wire logic_voltage_select_o,
  input wire fast_regulator_on_o,
  input wire slow_regulator_halver_o,
  input wire lcd_supply_halver_o,
  input wire lcd_supply_on_o,
  input wire lcd_circuit_active_o,
  input wire [3:0] contrast_code_o,
  input wire halver_running_o
);
  wire [3:0] sup = {lcd_supply_halver_o, slow_regulator_halver_o, fast_regulator_on_o,
    logic_voltage_select_o};
  wire we = clk_en_i & wr_i;
  wire lcd_ok = lcd_circuit_active_o == (lcd_supply_on_o & ~ext_lcd_supply_i);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  a_reset_clear: assert property ($fell(rst_i) |-> sup == 4'h0 && !lcd_supply_on_o)
    else $error("bits set after reset");
  a_lcd_gate: assert property (lcd_ok) else $error("lcd circuit gate");
  a_halver_on: assert property (halver_running_o) else $error("halver stopped");
  a_supply_wr: assert property (we && addr_i == 16'hff00 |=> sup == $past(wdata_i))
    else $error("supply write");
  a_lcd_wr: assert property (we && addr_i == 16'hff60 |=>
    lcd_supply_on_o == $past(wdata_i[0])) else $error("lcd write");
  a_supply_rd: assert property (addr_i == 16'hff00 |-> rdata_o == sup)
    else $error("supply read");
  a_lcd_rd: assert property (addr_i == 16'hff60 |-> rdata_o == {3'h0, lcd_supply_on_o})
    else $error("lcd read");
  a_contrast_ld: assert property (clk_en_i && contrast_wr_i |=>
    contrast_code_o == $past(contrast_code_i)) else $error("contrast load");
  a_frozen_en: assert property (!clk_en_i |=> $stable(sup))
    else $error("write while frozen");
  a_unmapped_rd: assert property (addr_i != 16'hff00 && addr_i != 16'hff60 |->
    rdata_o == 4'h0) else $error("unmapped read");
  c_supply: cover property (we && addr_i == 16'hff00);
  c_halvers: cover property (slow_regulator_halver_o && lcd_supply_halver_o);
  c_contrast: cover property (clk_en_i && contrast_wr_i);
  c_ext: cover property (ext_lcd_supply_i && lcd_supply_on_o);
endmodule // pmc_chk
bind power_mode_control pmc_chk u_chk (.*);

// ---- tb/test_power_mode_control.sv ----
// self-checking bench for the power mode control block
`timescale 1ns/1ps
module test_power_mode_control;
  reg clock_i = 0, rst_i = 1, clk_en_i = 1, wr_i = 0, contrast_wr_i = 0, ext_lcd_supply_i = 0;
  reg cpu_clock_select_i = 0, clock_select_wr_i = 0, fast_osc_on_i = 0, fast_osc_wr_i = 0;
  reg [15:0] addr_i = 16'hff00;
  reg [3:0] wdata_i = 4'h0, contrast_code_i = 4'h0;
  wire [3:0] rdata_o, contrast_code_o;
  wire logic_voltage_select_o, fast_regulator_on_o, slow_regulator_halver_o, lcd_supply_halver_o;
  wire lcd_supply_on_o, lcd_circuit_active_o, cpu_clock_select_o, fast_osc_on_o, halver_running_o;
  integer err_count = 0, checks_done = 0, i;
  wire [7:0] mode_bits = {2'h0, cpu_clock_select_o, fast_osc_on_o, lcd_supply_halver_o,
    slow_regulator_halver_o, fast_regulator_on_o, logic_voltage_select_o};
  power_mode_control DUT (.*);
  initial forever #25 clock_i = ~clock_i;
  task cyc; begin @(posedge clock_i); #1; end endtask
  task cmp(input string n, input [7:0] e, input [7:0] g);
    begin
      checks_done = checks_done + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("CHECK FAILED %s exp %h got %h", n, e, g);
      end
    end
  endtask
  task w(input [15:0] a, input [3:0] d);
    begin cyc; addr_i = a; wdata_i = d; wr_i = 1; cyc; wr_i = 0; end
  endtask
  task t_reset;
    begin
      cmp("rdata", 8'h00, {4'h0, rdata_o});
      cmp("state", 8'h01, {contrast_code_o, lcd_supply_on_o, cpu_clock_select_o, fast_osc_on_o,
        halver_running_o});
      $display("reset test done");
    end
  endtask
  task t_regs;
    begin
      for (i = 0; i < 16; i = i + 1) begin
        w(16'hff00, i[3:0]);
        cmp("ff00", {4'h0, i[3:0]}, {4'h0, rdata_o});
      end
      w(16'hff60, 4'hf);
      cmp("ff60", 8'h01, {4'h0, rdata_o});
      clk_en_i = 0;
      w(16'hff00, 4'h0);
      clk_en_i = 1;
      cmp("frozen", 8'h0f, {4'h0, rdata_o});
      w(16'hff01, 4'h0);
      addr_i = 16'hff00;
      #1;
      cmp("unmapped", 8'h0f, {4'h0, rdata_o});
      $display("register test done");
    end
  endtask
  task t_lcd;
    begin
      cmp("lcd on", 8'h01, {7'h0, lcd_circuit_active_o});
      ext_lcd_supply_i = 1;
      #1;
      cmp("lcd ext", 8'h00, {7'h0, lcd_circuit_active_o});
      ext_lcd_supply_i = 0;
      $display("lcd test done");
    end
  endtask
  task t_load;
    begin
      for (i = 15; i >= 0; i = i - 1) begin
        cyc; contrast_code_i = i[3:0]; contrast_wr_i = 1; cyc; contrast_wr_i = 0;
        cmp("contrast", {4'h0, i[3:0]}, {4'h0, contrast_code_o});
      end
      cyc; {cpu_clock_select_i, fast_osc_on_i, clock_select_wr_i, fast_osc_wr_i} = 4'hf;
      cyc; {clock_select_wr_i, fast_osc_wr_i} = 2'h0;
      cmp("clock osc", 8'h03, {6'h0, cpu_clock_select_o, fast_osc_on_o});
      $display("load test done");
    end
  endtask
  task ld_clk(input v);
    begin cyc; cpu_clock_select_i = v; clock_select_wr_i = 1; cyc; clock_select_wr_i = 0; end
  endtask
  task ld_osc(input v);
    begin cyc; fast_osc_on_i = v; fast_osc_wr_i = 1; cyc; fast_osc_wr_i = 0; end
  endtask
  task ld_con(input [3:0] v);
    begin cyc; contrast_code_i = v; contrast_wr_i = 1; cyc; contrast_wr_i = 0; end
  endtask
  // software waits are shortened: the block does not time them and the full
  // figures would not fit the run; the supply check lies outside this block
  task t_mode;
    begin
      w(16'hff00, 4'h0);
      w(16'hff00, 4'h2);
      w(16'hff00, 4'h3);
      cmp("regulator up", 8'h03, mode_bits);
      repeat (50) cyc;
      ld_osc(1'b1);
      repeat (100) cyc;
      ld_clk(1'b1);
      cmp("high speed", 8'h33, mode_bits);
      ld_clk(1'b0);
      ld_osc(1'b0);
      w(16'hff00, 4'h2);
      w(16'hff00, 4'h0);
      cmp("low speed", 8'h00, mode_bits);
      w(16'hff00, 4'h4);
      cmp("slow halver", 8'h04, mode_bits);
      ld_con(4'h6);
      w(16'hff00, 4'hc);
      cmp("both halvers", 8'h0c, mode_bits);
      cmp("contrast six", 8'h06, {4'h0, contrast_code_o});
      w(16'hff60, 4'h1);
      cmp("lcd bit", 8'h01, {7'h0, lcd_supply_on_o});
      $display("mode test done");
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  initial begin
    cyc; cyc; rst_i = 0;
    t_reset; t_regs; t_lcd; t_load;
    rst_i = 1; cyc; rst_i = 0;
    t_reset; t_mode;
    wrap_up;
  end
endmodule // test_power_mode_control
